// ---- bench/sdl_spi_mst.sv ----
`timescale 1ns/1ps
// serial master model: clock idles high; between frames the stray task wiggles it while deselected
module sdl_spi_mst (
  output logic lclk,  // serial clock, 80 ns period in frames
  output logic cs_n,  // chip select, active low
  output logic sdi    // serial data toward the device
);
  initial begin
    lclk = 1'b1;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // one frame of n bits, msb first, data changed on the falling edge
  task automatic send(input logic [31:0] d, input int n);
    cs_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      lclk = 1'b0;
      sdi  = d[i];
      #40;
      lclk = 1'b1;
      #40;
    end
    #20 cs_n = 1'b1;
    sdi = ~sdi; // released line shows no stale value
    #100;
  endtask
  // clock and data wiggle while deselected; the device must not care
  task automatic stray(input logic [15:0] d);
    for (int i = 0; i < 16; i++) begin
      lclk = 1'b0;
      sdi  = d[i];
      #40 lclk = 1'b1;
      #40;
    end
  endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import sdl_pkg::*;
  logic SYS_CLK, RST_B, strobe_n, lclk, cs_n, sdi, upd;
  logic [15:0] in_w, lat_w, shd, w, prev, imm_lat;
  logic [14:0] seg;
  logic [11:0] lad;
  int fail_count, checks_done, cyc, upd_cnt;
  // ************************************************************
  // design, serial master and clocks
  // ************************************************************
  sdl_dac_if #(.HAS_STROBE(1'b1)) sdl_dac_if_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .LNK_CLK(lclk), .CS_N(cs_n), .SDI(sdi), .LATCH_LOAD_STROBE_N(strobe_n),
    .INPUT_WORD(in_w), .LATCH_WORD(lat_w), .SEG_CTRL(seg), .LADDER_CTRL(lad),
    .LATCH_UPD(upd));
  // immediate-load variant on the same link
  if (1'b1) begin : g_imm
    sdl_dac_if #(.HAS_STROBE(1'b0)) sdl_dac_if_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
      .LNK_CLK(lclk), .CS_N(cs_n), .SDI(sdi), .LATCH_LOAD_STROBE_N(strobe_n),
      .INPUT_WORD(), .LATCH_WORD(imm_lat), .SEG_CTRL(), .LADDER_CTRL(),
      .LATCH_UPD());
  end
  sdl_spi_mst sdl_spi_mst_i (.lclk(lclk), .cs_n(cs_n), .sdi(sdi));
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  // hang guard, well above the expected run length
  always @(posedge SYS_CLK) begin
    cyc++;
    if (upd === 1'b1) upd_cnt++;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end
  // ************************************************************
  // expectation helpers
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [14:0] therm(input logic [3:0] c);
    for (int k = 0; k < 15; k++) therm[k] = (c > k);
  endfunction
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // send a frame, wait for the crossing, compare the input register
  task automatic frame(input logic [31:0] d, input int n);
    sdl_spi_mst_i.send(d, n);
    shd = (n >= 16) ? d[15:0] : 16'((shd << n) | d[15:0]);
    repeat (10) @(negedge SYS_CLK);
    `CHK(in_w, shd)
    `CHK(imm_lat, shd)
  endtask
  task automatic strobe_chk();
    int n0;
    logic [15:0] l0;
    n0 = upd_cnt;
    l0 = lat_w;
    strobe_n = 1'b0;
    repeat (8) @(negedge SYS_CLK);
    strobe_n = 1'b1;
    `CHK(lat_w, shd)
    `CHK(seg, therm(shd[15:12]))
    `CHK(lad, shd[11:0])
    `CHK(upd_cnt - n0, (l0 != shd) ? 1 : 0)
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    RST_B = 1'b0;
    strobe_n = 1'b1;
    w = 16'hD9A5;
    repeat (8) @(negedge SYS_CLK);
    RST_B = 1'b1;
    repeat (4) @(negedge SYS_CLK);
    `CHK(in_w, WORD_RST)
    `CHK(lat_w, WORD_RST)
    `CHK(seg, SEG_RST)
    `CHK(imm_lat, WORD_RST)
    for (int j = 0; j < 8; j++) begin
      w = lfsr(w);
      prev = lat_w;
      frame({16'h0000, (j == 0) ? 16'hFFFF : (j == 1) ? 16'h0000 : w}, 16);
      `CHK(lat_w, prev)
      strobe_chk();
    end
    sdl_spi_mst_i.stray(lfsr(w));
    repeat (10) @(negedge SYS_CLK);
    `CHK(in_w, shd)
    frame(32'h0000_00A5, 8);
    frame(32'h0003_C35A, 20);
    frame(32'h0000_0005, 3);
    w = lfsr(w);
    frame({16'h0000, w}, 16);
    strobe_chk();
    w = lfsr(w);
    frame({16'h0000, w[11:0], 4'h0}, 16);
    strobe_chk();
    strobe_n = 1'b0;
    for (int j = 0; j < 3; j++) begin
      w = lfsr(w);
      frame({16'h0000, w}, 16);
      `CHK(lat_w, shd)
    end
    conclude();
  end
endmodule

// ---- hw/sdl_dac_if.sv ----
`timescale 1ns/1ps
// ************************************************************
// ************************************************************
module sdl_dac_if
  import sdl_pkg::*;
#(
  parameter bit HAS_STROBE = 1'b1
) (
  input  wire logic                    SYS_CLK,            // system clock
  input  wire logic                    RST_B,              // power-on reset, active low
  input  wire logic                    LNK_CLK,            // serial clock from master
  input  wire logic                    CS_N,               // chip select, active low
  input  wire logic                    SDI,                // serial data in
  input  wire logic                    LATCH_LOAD_STROBE_N, // latch load strobe, active low
  output logic [sdl_pkg::WORD_W-1:0]   INPUT_WORD,         // input register
  output logic [sdl_pkg::WORD_W-1:0]   LATCH_WORD,         // converter latch, unsigned
  output logic [sdl_pkg::SEG_N-1:0]    SEG_CTRL,           // thermometer segment controls
  output logic [sdl_pkg::LADDER_W-1:0] LADDER_CTRL,        // ladder switch controls
  output logic                         LATCH_UPD           // pulse when latch loads a changed value
);
  import sdl_pkg::*;

  logic [WORD_W-1:0] shift_word;
  logic [2:0]        cs_sync_ff;
  logic [1:0]        ld_sync_ff;
  logic [WORD_W-1:0] snap_ff;
  logic [WORD_W-1:0] nxt_latch;
  logic              cs_rise;
  logic              ld_low;
  logic              load_latch;
  logic              nxt_upd;
  logic [SEG_N-1:0]  seg_w;
  logic [3:0]        ld_run_ff;

  // ************************************************************
  // link-domain shift register
  // ************************************************************
  sdl_shift #(.W(WORD_W)) u_shift (
    .LNK_CLK    (LNK_CLK),
    .CS_N       (CS_N),
    .SDI        (SDI),
    .SHIFT_WORD (shift_word)
  );

  // snapshot at select rise; word is stable while select is high
  always_ff @(posedge CS_N) begin
    snap_ff <= shift_word;
  end

  // ************************************************************
  // clock crossing
  // ************************************************************
  // three clocks meet here: the serial clock shifts, the select rise
  // snapshots, the system clock loads the registers
  // the snapshot is written once per frame and then held for the whole
  // time select stays high, which is far longer than the two system
  // edges the select synchroniser needs, so the word is settled before
  // the system domain reads it
  // a select high time below a few system cycles can be missed by the
  // synchroniser; the master keeps well above it
  // the strobe is a level, so a plain two-flop synchroniser suffices

  // ************************************************************
  // synchronisers into the system domain
  // ************************************************************
  // select passes two flops, third flop for edge detect
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cs_sync_ff <= 3'b111;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], CS_N};
    end
  end

  // strobe level, two flops
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ld_sync_ff <= 2'b11;
    end else begin
      ld_sync_ff <= {ld_sync_ff[0], LATCH_LOAD_STROBE_N};
    end
  end

  assign cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];
  // strobe only counts while select is high
  assign ld_low  = HAS_STROBE ? (~ld_sync_ff[1] & cs_sync_ff[1]) : 1'b1;

  // ************************************************************
  // input register
  // ************************************************************
  // with the strobe, the input register is the only word the rest sees change; it
  // moves once per completed frame and never on a half-shifted word
  // loads only at select rise, cleared at power-up
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      INPUT_WORD <= WORD_RST;
    end else if (cs_rise) begin
      INPUT_WORD <= snap_ff;
    end
  end

  // ************************************************************
  // converter latch
  // ************************************************************
  // the latch drives the switches, so every move of it is a glitch on
  // the output; it moves only when a new value is actually loaded
  // a strobe held low during a frame is not obeyed until select is
  // seen high again, so a tied-low strobe loads right after the input
  // without strobe: load with input; with strobe: follow while low
  always_comb begin
    nxt_latch  = LATCH_WORD;
    load_latch = 1'b0;
    if (!HAS_STROBE && cs_rise) begin
      nxt_latch  = snap_ff;
      load_latch = 1'b1;
    end else if (HAS_STROBE && ld_low) begin
      nxt_latch  = INPUT_WORD;
      load_latch = 1'b1;
    end
  end

  assign nxt_upd = load_latch && (nxt_latch != LATCH_WORD);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LATCH_WORD <= WORD_RST;
    end else begin
      LATCH_WORD <= nxt_latch;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LATCH_UPD <= 1'b0;
    end else begin
      LATCH_UPD <= nxt_upd;
    end
  end

  // ************************************************************
  // switch controls
  // ************************************************************
  sdl_seg_dec #(.NB(SEG_BITS), .NS(SEG_N)) u_seg (
    .CODE (nxt_latch[WORD_W-1 -: SEG_BITS]),
    .SEG  (seg_w)
  );

  // decode works on the next latch value so that segments and ladder
  // land on the same edge as the latch itself
  // registered so switches move together with the latch
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SEG_CTRL    <= SEG_RST;
      LADDER_CTRL <= WORD_RST[LADDER_W-1:0];
    end else begin
      SEG_CTRL    <= seg_w;
      LADDER_CTRL <= nxt_latch[LADDER_W-1:0];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_cs_rise;
    $rose(cs_sync_ff[1]);
  endsequence

  AST_INPUT_ONLY_AT_RISE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $changed(INPUT_WORD) |-> $past(cs_rise)) else $error("input word moved without select rise");
  AST_INPUT_LOADS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    cs_rise |=> INPUT_WORD == $past(snap_ff)) else $error("input word not loaded");
  AST_LATCH_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (HAS_STROBE && ld_low) |=> LATCH_WORD == $past(INPUT_WORD)) else $error("latch not following");
  AST_LATCH_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (HAS_STROBE && !ld_low) |=> $stable(LATCH_WORD)) else $error("latch moved without strobe");
  AST_NO_STROBE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    s_cs_rise |=> (HAS_STROBE || LATCH_WORD == INPUT_WORD))
    else $error("latch not loaded with input");
  AST_SEG_DECODE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ##1 SEG_CTRL == SEG_N'((1 << LATCH_WORD[15:12]) - 1)) else $error("segment decode wrong");
  AST_LADDER: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ##1 LADDER_CTRL == LATCH_WORD[11:0]) else $error("ladder bits wrong");
  AST_RESET_ZERO: assert property (@(posedge SYS_CLK)
    $rose(RST_B) |-> INPUT_WORD == WORD_RST && LATCH_WORD == WORD_RST)
    else $error("registers not cleared");

  // ************************************************************
  // check helpers
  // ************************************************************
  // run length of an accepted strobe, saturating at the least strobe
  // width; a strobe of least width always reaches the ceiling, so the
  // latch has time to settle inside any legal strobe
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ld_run_ff <= 4'h0;
    end else if (!ld_low) begin
      ld_run_ff <= 4'h0;
    end else if (ld_run_ff != 4'(LOAD_MIN_CYC)) begin
      ld_run_ff <= ld_run_ff + 4'h1;
    end
  end

  // select seen high for two edges after its rise
  sequence s_select_settled;
    cs_rise ##1 cs_sync_ff[1] ##1 cs_sync_ff[1];
  endsequence

  // strobe accepted on two edges in a row
  sequence s_strobe_held;
    ld_low ##1 ld_low;
  endsequence

  // ************************************************************
  // further checks
  // ************************************************************
  // immediate variant takes the snapshot on the edge of the input load
  AST_NO_STROBE_SNAP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!HAS_STROBE && cs_rise) |=> LATCH_WORD == $past(snap_ff))
    else $error("latch missed the snapshot");

  // a strobe held for two edges leaves latch equal to input
  AST_STROBE_SETTLED: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (HAS_STROBE && ld_run_ff >= 4'h2) |-> LATCH_WORD == INPUT_WORD)
    else $error("latch not settled under strobe");

  // held strobe loads the input on the following edge
  AST_STROBE_HELD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    s_strobe_held |=> (!HAS_STROBE || LATCH_WORD == INPUT_WORD))
    else $error("held strobe did not load");

  // input holds the snapshot taken at the select rise
  AST_SELECT_SETTLED: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    s_select_settled |-> INPUT_WORD == $past(snap_ff, 2))
    else $error("input lost the snapshot");

  // no second load while select stays high
  AST_INPUT_AFTER_SETTLE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    s_select_settled |=> $stable(INPUT_WORD))
    else $error("input moved while select high");

  // every latch move is flagged
  AST_UPD_ON_CHANGE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $changed(LATCH_WORD) |-> LATCH_UPD)
    else $error("latch moved without update flag");

  // no flag without a latch move
  AST_UPD_ONLY_ON_CHANGE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    LATCH_UPD |-> $changed(LATCH_WORD))
    else $error("update flag without latch move");

  // select rise seen for one system cycle only
  AST_CS_RISE_ONCE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    cs_rise |=> !cs_rise)
    else $error("select rise seen twice");

  // segments always form a thermometer from the bottom
  AST_SEG_THERMO: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ((16'(SEG_CTRL) + 16'h0001) & 16'(SEG_CTRL)) == 16'h0000)
    else $error("segments not a thermometer");

  // top segment on only for the full-scale top code
  AST_SEG_TOP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    SEG_CTRL[SEG_N-1] == (LATCH_WORD[WORD_W-1 -: SEG_BITS] == 4'hF))
    else $error("top segment wrong");

  // input register frozen while select is low
  AST_INPUT_HOLD_IN_FRAME: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !cs_sync_ff[1] |=> $stable(INPUT_WORD))
    else $error("input moved during frame");

  // strobe not obeyed while select is low
  AST_LATCH_HOLD_IN_FRAME: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (HAS_STROBE && !cs_sync_ff[1]) |=> $stable(LATCH_WORD))
    else $error("latch moved during frame");

  // ladder follows the input under a settled strobe
  AST_LADDER_FROM_INPUT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (HAS_STROBE && ld_run_ff >= 4'h2) |-> LADDER_CTRL == INPUT_WORD[LADDER_W-1:0])
    else $error("ladder not from input");

  // ladder picks up the input one edge after an accepted strobe
  AST_LADDER_LOAD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (HAS_STROBE && ld_low) |=> LADDER_CTRL == $past(INPUT_WORD[LADDER_W-1:0]))
    else $error("ladder not loaded");

  // switch outputs and flag cleared at power-up
  AST_RESET_OUTPUTS: assert property (@(posedge SYS_CLK)
    $rose(RST_B) |-> SEG_CTRL == SEG_RST && !LATCH_UPD &&
      LADDER_CTRL == WORD_RST[LADDER_W-1:0])
    else $error("outputs not cleared");
endmodule

// ---- hw/sdl_pkg.sv ----
package sdl_pkg;
  // ************************************************************
  // word format and segment decode
  // ************************************************************
  localparam int WORD_W            = 16;            // bits per frame word
  localparam int SEG_BITS          = 4;             // top bits decoded to segments
  localparam int SEG_N             = 15;            // thermometer segment controls
  localparam int LADDER_W          = 12;            // ladder switch bits
  localparam logic [15:0] WORD_RST = 16'h0000;      // cleared register value
  localparam logic [14:0] SEG_RST  = 15'h0000;      // cleared segment value
  // ************************************************************
  // timing figures
  // ************************************************************
  localparam int SYS_PERIOD_PS     = 5000;          // system clock period
  localparam int LOAD_MIN_NS       = 30;            // least load strobe width
  localparam int LOAD_MIN_CYC      = (LOAD_MIN_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
endpackage

// ---- hw/sdl_seg_dec.sv ----
`timescale 1ns/1ps
// thermometer decode of the top bits of the latch word
module sdl_seg_dec #(
  parameter int NB = 4,
  parameter int NS = 15
) (
  input  wire logic [NB-1:0] CODE,            // top code bits
  output logic      [NS-1:0] SEG              // thermometer controls
);
  // ************************************************************
  // segment k is on when code exceeds k
  // ************************************************************
  for (genvar k = 0; k < NS; k++) begin : g_seg
    assign SEG[k] = (32'(CODE) > k);
  end
endmodule

// ---- hw/sdl_shift.sv ----
`timescale 1ns/1ps
// serial shift register on the link clock, captures on rising edge
module sdl_shift #(
  parameter int W = 16
) (
  input  wire logic         LNK_CLK,          // serial clock from master
  input  wire logic         CS_N,             // chip select, active low
  input  wire logic         SDI,              // serial data in
  output logic [W-1:0]      SHIFT_WORD        // shift register content
);
  // ************************************************************
  // shift register, never reset
  // ************************************************************
  // ignored while select high; msb first; older bits kept when short
  always_ff @(posedge LNK_CLK) begin
    if (!CS_N) begin
      SHIFT_WORD <= {SHIFT_WORD[W-2:0], SDI};
    end
  end
endmodule
